// ==== sim/scl_rom_model.sv ====
/*
 * behavioural serial config rom: takes start bit, read opcode and word
 * address on rising clocks, then shifts out a 16-bit word msb first.
 * assumes chip select active high and a pull-down on its data output.
 */
`timescale 1ns/1ps
module scl_rom_model #(
    parameter int TPD_NS = 0
) (
    input  wire logic sk_i,
    input  wire logic cs_i,
    input  wire logic di_i,
    output logic      do_o,
    output int        n_frames_o,
    output int        n_bad_o
);
    logic [8:0]  cmd_reg = 9'h000;
    logic [15:0] word;
    int          rises = 0;

    initial begin
        do_o = 1'b0;
        n_frames_o = 0;
        n_bad_o = 0;
    end

    // ****************************************
    // serial engine
    // ****************************************
    // input sampled on rise, output launched after rise
    always @(posedge sk_i) begin
        if (cs_i) begin
            rises = rises + 1;
            if (rises <= 9) begin
                cmd_reg = {cmd_reg[7:0], di_i};
            end
            word = 16'h8c31 + 16'h0101 * {13'h0000, cmd_reg[2:0]};
            if (rises >= 10 && rises <= 25) begin
                do_o <= #(TPD_NS) word[25 - rises];
            end else begin
                do_o <= #(TPD_NS) 1'b0;  // dummy zero ahead of data
            end
        end
    end

    // deselect ends the frame; output falls to its pull-down level
    always @(negedge cs_i) begin
        if (rises != 25 || cmd_reg !== {6'h30, n_frames_o[2:0]}) begin
            n_bad_o = n_bad_o + 1;
        end
        n_frames_o = n_frames_o + 1;
        rises = 0;
        do_o <= 1'b0;
    end
endmodule

// ==== sim/tb.sv ====
/*
 * self-checking bench for the serial rom loader: wishbone tasks, strap
 * pins and a rom model. assumes the loader ports as declared in src.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        pres = 1'b1;
    logic        endn = 1'b1;
    logic        tgl = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] q;
    wire  [31:0] rdat;
    wire         ack, sk_o, sk_oe, cs, dout, big, busy, done, rom_do;
    wire         sk_w = sk_oe ? sk_o : endn;  // driver or strap pull
    wire         din = pres ? rom_do : tgl;   // absent rom: pin wanders
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          n_frames, n_bad, cnt, hmin, hmax;
    logic        sk_q = 1'b0;
    logic        seen = 1'b0;
    logic        cs_seen = 1'b0;

    scl_loader dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rom_present_strap_i(pres),
        .serial_in_from_rom_i(din), .rom_serial_clock_i(sk_w),
        .rom_serial_clock_o(sk_o), .rom_serial_clock_oe_o(sk_oe),
        .rom_select_out_o(cs), .serial_out_to_rom_o(dout), .big_endian_o(big),
        .load_busy_o(busy), .load_done_o(done));
    scl_rom_model #(.TPD_NS(60)) rom (.sk_i(sk_w), .cs_i(cs), .di_i(dout),
        .do_o(rom_do), .n_frames_o(n_frames), .n_bad_o(n_bad));

    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) tgl <= ~tgl;

    // ****************************************
    // serial clock half period monitor
    // ****************************************
    // only halves inside a frame count; sel and deselect gaps differ on purpose
    always @(posedge clk_i) begin
        if (cs) cs_seen = 1'b1;
        if (!cs) begin
            seen = 1'b0;
        end else if (sk_o !== sk_q) begin
            if (seen && cnt < hmin) hmin = cnt;
            if (seen && cnt > hmax) hmax = cnt;
            seen = 1'b1;
            cnt = 1;
        end else begin
            cnt = cnt + 1;
        end
        sk_q = sk_o;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic results;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        // ack and data are read at the rising edge, before the slave's update lands
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            n_mismatch++;
            results();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        `CHK(q, exp)
    endtask

    task automatic do_reset(input logic p, input logic e);
        @(posedge clk_i);
        rst_i <= 1'b1;
        pres <= p;
        endn <= e;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        hmin = 255;
        hmax = 0;
        cs_seen = 1'b0;
        @(negedge clk_i);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // waits for a whole load, then checks timing, framing, status and words
    task automatic t_load(input int h, input int frames, input logic [31:0] st);
        int n = 0;
        while (done !== 1'b1 && n < 12000) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 12000) begin
            n_mismatch++;
            results();
        end
        `CHK(hmin, h)
        `CHK(hmax, h)
        `CHK(n_bad, 0)
        `CHK(n_frames, frames)
        `CHK({cs, sk_oe, busy}, 3'h0)
        rd(scl_pkg::ADR_STATUS, st);
        for (int i = 0; i < 8; i++) begin
            rd(scl_pkg::ADR_DATA0 + 8'(4 * i), {16'h0000, 16'h8c31 + 16'(i) * 16'h0101});
        end
    endtask

    task automatic t_power_up;
        do_reset(1'b1, 1'b1);
        `CHK({cs, sk_oe, ack, done}, 4'h0)
        rd(scl_pkg::ADR_CTRL, 32'h0000_0006);
        t_load(20, 8, 32'h0000_000e);
        `CHK(big, 1'b1)
    endtask

    // software reload at a chosen speed code; framing and words must repeat
    task automatic t_reload(input logic [1:0] spd, input int h, input int frames);
        hmin = 255;
        hmax = 0;
        wb(1'b1, scl_pkg::ADR_CTRL, {29'h0, spd, 1'b1});
        rd(scl_pkg::ADR_CTRL, {29'h0, spd, 1'b0});
        t_load(h, frames, 32'h0000_000e);
    endtask

    // unmapped and read-only places must not take writes
    task automatic t_bus_map;
        wb(1'b1, 8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0000_0000);
        wb(1'b1, scl_pkg::ADR_STATUS, 32'h0000_0001);
        rd(scl_pkg::ADR_STATUS, 32'h0000_000e);
    endtask

    // strap low: no frame at reset nor on reload, wandering input ignored
    task automatic t_absent;
        do_reset(1'b0, 1'b0);
        repeat (300) @(posedge clk_i);
        wb(1'b1, scl_pkg::ADR_CTRL, 32'h0000_0001);
        repeat (300) @(posedge clk_i);
        @(negedge clk_i);
        `CHK(cs_seen, 1'b0)
        `CHK({sk_oe, busy, done, big}, 4'h0)
        `CHK(n_frames, 32)
        rd(scl_pkg::ADR_STATUS, 32'h0000_0000);
    endtask

    initial begin
        t_power_up();
        t_reload(2'h0, 4, 16);
        t_reload(2'h1, 8, 24);
        t_reload(2'h2, 12, 32);
        t_bus_map();
        t_absent();
        results();
    end
endmodule

// ==== src/scl_half_divider.sv ====
/*
 * half period divider: one-cycle tick every half_i cycles while enabled.
 * assumes half_i is at least one and stays steady while enabled.
 */
`timescale 1ns/1ps
module scl_half_divider (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    input  wire logic [7:0] half_i,
    output wire logic       tick_o
);
    logic [7:0] cnt_reg;

    // ****************************************
    // counter
    // ****************************************
    // tick is combinational so it lines up with the count wrap
    assign tick_o = en_i && (cnt_reg == half_i - 8'h01);

    // restart from zero whenever disabled so the first half is full length
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i || tick_o) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule

// ==== src/scl_loader.sv ====
/*
 * serial rom config loader: reads a serial eeprom over four wires after
 * reset, keeps the words for software, and latches the endian strap.
 * assumes a 10 MHz clk_i, a classic wishbone master and pulled strap pins.
 */
`timescale 1ns/1ps
module scl_loader (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rom_present_strap_i,
    input  wire logic        serial_in_from_rom_i,
    input  wire logic        rom_serial_clock_i,
    output logic             rom_serial_clock_o,
    output wire logic        rom_serial_clock_oe_o,
    output logic             rom_select_out_o,
    output logic             serial_out_to_rom_o,
    output logic             big_endian_o,
    output wire logic        load_busy_o,
    output logic             load_done_o
);
    scl_pkg::scl_state_t         state_reg;
    logic [1:0]                  strap_cnt_reg;
    logic [1:0]                  present_sync_reg;
    logic [1:0]                  din_sync_reg;
    logic [1:0]                  sk_sync_reg;
    logic                        present_reg;
    logic [1:0]                  speed_reg;
    logic [1:0]                  speed_act_reg;
    logic                        reload_reg;
    logic                        started_reg;
    logic [2:0]                  word_reg;
    logic [4:0]                  rise_reg;
    logic [scl_pkg::CMD_W-1:0]   cmd_reg;
    logic [scl_pkg::WORD_W-1:0]  rx_reg;
    logic [scl_pkg::WORD_W-1:0]  mem [scl_pkg::ROM_WORDS];

    wire logic       tick;
    wire logic [7:0] half;
    wire logic       din_gated;
    wire logic       strap_done;
    wire logic       start_req;
    wire logic       sample_en;
    wire logic       bus_req;
    wire logic       wr_ctrl;
    wire logic       hit_data;
    wire logic [31:0] rd_data;

    // ****************************************
    // helpers
    // ****************************************
    // half period per speed code; the two middle codes sit between the ends
    function automatic logic [7:0] half_of(input logic [1:0] spd);
        case (spd)
            2'h0:    half_of = scl_pkg::HALF_00;
            2'h1:    half_of = scl_pkg::HALF_01;
            2'h2:    half_of = scl_pkg::HALF_10;
            default: half_of = scl_pkg::HALF_11;
        endcase
    endfunction

    // ****************************************
    // pin synchronisers and strap capture
    // ****************************************
    // two flops on every pin; only the second stage is read
    always_ff @(posedge clk_i) begin
        present_sync_reg <= {present_sync_reg[0], rom_present_strap_i};
        din_sync_reg     <= {din_sync_reg[0], serial_in_from_rom_i};
        sk_sync_reg      <= {sk_sync_reg[0], rom_serial_clock_i};
    end

    // straps are caught three cycles after release, once the synchronisers hold them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_cnt_reg <= 2'h0;
            present_reg   <= 1'b0;
            big_endian_o  <= 1'b0;
        end else if (strap_cnt_reg != scl_pkg::STRAP_DONE) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == scl_pkg::STRAP_LATCH) begin
                present_reg  <= present_sync_reg[1];
                big_endian_o <= sk_sync_reg[1];
            end
        end
    end

    assign strap_done = (strap_cnt_reg == scl_pkg::STRAP_DONE);
    // an absent rom leaves the data pin floating, so it is masked to zero
    assign din_gated  = present_reg & din_sync_reg[1];

    // ****************************************
    // wishbone slave
    // ****************************************
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == scl_pkg::ADR_CTRL);
    assign hit_data = (wb_adr_i & scl_pkg::ADR_DATA_MASK) == scl_pkg::ADR_DATA0;
    assign rd_data  = (wb_adr_i == scl_pkg::ADR_CTRL)   ? {29'h0, speed_reg, 1'b0} :
                      (wb_adr_i == scl_pkg::ADR_STATUS) ? {28'h0, big_endian_o, present_reg,
                                                           load_done_o, load_busy_o} :
                      hit_data ? {16'h0, mem[wb_adr_i[4:2]]} : 32'h0;

    // one wait state on every access; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
            speed_reg  <= scl_pkg::SPEED_RESET;
            reload_reg <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= rd_data;
            end
            if (wr_ctrl) begin
                speed_reg <= wb_dat_i[scl_pkg::CTRL_SPEED_LSB +: 2];
            end
            // a reload request waits until the loader is idle
            if (wr_ctrl && wb_dat_i[scl_pkg::CTRL_RELOAD_BIT]) begin
                reload_reg <= 1'b1;
            end else if (start_req) begin
                reload_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // serial clock divider
    // ****************************************
    assign half = half_of(speed_act_reg);

    scl_half_divider u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (state_reg != scl_pkg::ST_IDLE),
        .half_i (half),
        .tick_o (tick)
    );

    // ****************************************
    // load sequencer
    // ****************************************
    // the first load follows the strap capture; later ones need software
    assign start_req = (state_reg == scl_pkg::ST_IDLE) && strap_done && present_reg &&
                       (reload_reg || (strap_cnt_reg == scl_pkg::STRAP_DONE && !load_done_o
                        && !started_reg));
    assign sample_en = tick && (state_reg == scl_pkg::ST_SHIFT) && rom_serial_clock_o &&
                       (rise_reg >= scl_pkg::DATA_FIRST_RISE);
    assign load_busy_o = (state_reg != scl_pkg::ST_IDLE);
    // release the clock pin outside a load so its strap resistor stays readable
    assign rom_serial_clock_oe_o = load_busy_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg           <= scl_pkg::ST_IDLE;
            started_reg         <= 1'b0;
            load_done_o         <= 1'b0;
            speed_act_reg       <= scl_pkg::SPEED_RESET;
            word_reg            <= 3'h0;
            rise_reg            <= 5'h0;
            cmd_reg             <= '0;
            rx_reg              <= '0;
            rom_select_out_o    <= 1'b0;
            rom_serial_clock_o  <= 1'b0;
            serial_out_to_rom_o <= 1'b0;
        end else begin
            case (state_reg)
                scl_pkg::ST_IDLE: begin
                    if (start_req) begin
                        started_reg      <= 1'b1;
                        load_done_o      <= 1'b0;
                        speed_act_reg    <= speed_reg;
                        word_reg         <= 3'h0;
                        rom_select_out_o <= 1'b1;
                        state_reg        <= scl_pkg::ST_SEL;
                    end
                end
                scl_pkg::ST_SEL: begin
                    if (tick) begin
                        // start bit, read opcode and address, msb first
                        serial_out_to_rom_o <= 1'b1;
                        cmd_reg   <= {scl_pkg::CMD_READ[1:0], 3'h0, word_reg, 1'b0};
                        rise_reg  <= 5'h0;
                        state_reg <= scl_pkg::ST_SHIFT;
                    end
                end
                scl_pkg::ST_SHIFT: begin
                    if (tick && !rom_serial_clock_o) begin
                        rom_serial_clock_o <= 1'b1;
                        rise_reg           <= rise_reg + 5'h1;
                    end else if (tick) begin
                        // data out changes only on the falling edge, or at the sel tick for the start bit
                        rom_serial_clock_o  <= 1'b0;
                        serial_out_to_rom_o <= cmd_reg[scl_pkg::CMD_W-1];
                        cmd_reg <= {cmd_reg[scl_pkg::CMD_W-2:0], 1'b0};
                        if (sample_en) begin
                            rx_reg <= {rx_reg[scl_pkg::WORD_W-2:0], din_gated};
                        end
                        if (rise_reg == scl_pkg::LAST_RISE) begin
                            mem[word_reg]    <= {rx_reg[scl_pkg::WORD_W-2:0], din_gated};
                            rom_select_out_o <= 1'b0;
                            state_reg        <= scl_pkg::ST_DESEL;
                        end
                    end
                end
                scl_pkg::ST_DESEL: begin
                    if (tick && word_reg == scl_pkg::LAST_WORD) begin
                        load_done_o <= 1'b1;
                        state_reg   <= scl_pkg::ST_IDLE;
                    end else if (tick) begin
                        word_reg         <= word_reg + 3'h1;
                        rom_select_out_o <= 1'b1;
                        state_reg        <= scl_pkg::ST_SEL;
                    end
                end
                default: begin
                    state_reg <= scl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rise;
        $rose(rom_serial_clock_o);
    endsequence

    property p_cs_shift;
        state_reg == scl_pkg::ST_SHIFT |-> rom_select_out_o;
    endproperty
    a_cs_shift: assert property (p_cs_shift) else $error("select low mid frame");

    property p_absent_skip;
        strap_done && !present_reg |-> state_reg == scl_pkg::ST_IDLE;
    endproperty
    a_absent_skip: assert property (p_absent_skip) else $error("load without rom");

    property p_do_stable_high;
        rom_serial_clock_o && $past(rom_serial_clock_o) |-> $stable(serial_out_to_rom_o);
    endproperty
    a_do_stable_high: assert property (p_do_stable_high) else $error("data moved");

    property p_sample;
        sample_en |=> rx_reg[0] == $past(din_gated);
    endproperty
    a_sample: assert property (p_sample) else $error("bit not sampled");

    property p_fast_high;
        s_rise ##0 speed_act_reg == 2'h0 |-> rom_serial_clock_o [*4] ##1 !rom_serial_clock_o;
    endproperty
    a_fast_high: assert property (p_fast_high) else $error("fast half wrong");

    property p_slow_high;
        s_rise ##0 speed_act_reg == 2'h3 |-> ##19 rom_serial_clock_o ##1 !rom_serial_clock_o;
    endproperty
    a_slow_high: assert property (p_slow_high) else $error("slow half wrong");

    property p_endian_hold;
        strap_done && $past(strap_done) |-> $stable(big_endian_o);
    endproperty
    a_endian_hold: assert property (p_endian_hold) else $error("endian moved");

    property p_din_masked;
        strap_done && !present_reg |-> !din_gated;
    endproperty
    a_din_masked: assert property (p_din_masked) else $error("input not masked");

    property p_start_bit;
        state_reg == scl_pkg::ST_SEL && tick |=> serial_out_to_rom_o ##0 !rom_serial_clock_o;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
endmodule

// ==== src/scl_pkg.sv ====
/*
 * constants, register map and state type for the serial rom config loader.
 * assumes a 10 MHz system clock and a classic wishbone register bus.
 */
package scl_pkg;

    // ****************************************
    // clock and serial clock timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SK_PERIOD_00_NS = 800;
    localparam int SK_PERIOD_01_NS = 1600;
    localparam int SK_PERIOD_10_NS = 2400;
    localparam int SK_PERIOD_11_NS = 4000;
    // half periods in clk cycles, the serial clock toggles once per half
    localparam logic [7:0] HALF_00 = 8'(SK_PERIOD_00_NS / (2 * CLK_PERIOD_NS));
    localparam logic [7:0] HALF_01 = 8'(SK_PERIOD_01_NS / (2 * CLK_PERIOD_NS));
    localparam logic [7:0] HALF_10 = 8'(SK_PERIOD_10_NS / (2 * CLK_PERIOD_NS));
    localparam logic [7:0] HALF_11 = 8'(SK_PERIOD_11_NS / (2 * CLK_PERIOD_NS));

    // ****************************************
    // serial rom framing
    // ****************************************
    localparam int         ROM_WORDS       = 8;
    localparam int         WORD_W          = 16;
    localparam int         CMD_W           = 9;
    localparam logic [2:0] CMD_READ        = 3'h6;
    localparam logic [4:0] DATA_FIRST_RISE = 5'h0a;
    localparam logic [4:0] LAST_RISE       = 5'h19;
    localparam logic [2:0] LAST_WORD       = 3'h7;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_DATA0  = 8'h40;
    localparam logic [7:0] ADR_DATA_MASK = 8'he3;
    localparam int         CTRL_RELOAD_BIT = 0;
    localparam int         CTRL_SPEED_LSB  = 1;
    localparam logic [1:0] SPEED_RESET     = 2'h3;
    localparam int         ST_BUSY_BIT     = 0;
    localparam int         ST_DONE_BIT     = 1;
    localparam int         ST_PRESENT_BIT  = 2;
    localparam int         ST_BIGEND_BIT   = 3;

    // ****************************************
    // strap capture after reset release
    // ****************************************
    localparam logic [1:0] STRAP_LATCH = 2'h2;
    localparam logic [1:0] STRAP_DONE  = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_SHIFT, ST_DESEL} scl_state_t;

endpackage
